//--- tb/radio_cfg_props.sv
// Checker of the configuration bank port behaviour.
`timescale 1ns/100ps
module radio_cfg_props
    import radio_cfg_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [4:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    input wire logic i_sync_on,
    input wire logic i_rx_bit_valid,
    input wire logic o_sync_found,
    input wire logic i_rx_addr_valid,
    input wire logic o_addr_reject,
    input wire logic o_fifo_store_en,
    input wire logic i_rx_crc_done,
    input wire logic i_rx_crc_ok,
    input wire logic o_fifo_clear,
    input wire tx_cfg_s o_tx_cfg,
    input wire pkt_cfg_s o_pkt_cfg,
    input wire logic o_clkout,
    input wire logic o_clkout_oe,
    input wire logic o_clkout_bypass
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n);
    logic wr_clk;
    assign wr_clk = i_reg_wr && i_reg_addr == ADDR_CLKOUT_SETTINGS;
    unmapped_read_a: assert property (i_reg_rd && i_reg_addr < ADDR_SYNC_MSB |=> o_reg_rdata == UNMAPPED_READ)
        else $error("unmapped read returned data");
    tx_settings_a: assert property (i_reg_wr && i_reg_addr == ADDR_TX_SETTINGS |=> o_tx_cfg == $past(i_reg_wdata))
        else $error("transmit settings not taken");
    clkout_enable_a: assert property (wr_clk |=> o_clkout_oe == $past(i_reg_wdata[7]))
        else $error("clock output enable wrong");
    clkout_quiet_a: assert property (!o_clkout_oe |-> !o_clkout && !o_clkout_bypass)
        else $error("clock output active while disabled");
    clkout_bypass_a: assert property (wr_clk |=> o_clkout_bypass ==
        ($past(i_reg_wdata[6:2]) == CLKDIV_BYPASS && $past(i_reg_wdata[7])))
        else $error("clock bypass wrong");
    node_address_a: assert property (i_reg_wr && i_reg_addr == ADDR_NODE_ADDRESS |=>
        o_pkt_cfg.node_address == $past(i_reg_wdata))
        else $error("node address not taken");
    reject_store_a: assert property (o_addr_reject |-> !o_fifo_store_en)
        else $error("rejected packet still stored");
    filter_off_a: assert property (i_rx_addr_valid && o_pkt_cfg.addr_filter == FILT_OFF |=> !o_addr_reject)
        else $error("reject with filtering off");
    clear_cause_a: assert property (o_fifo_clear |-> $past(i_rx_crc_done) && !$past(i_rx_crc_ok))
        else $error("fifo clear without failed check");
    sync_off_a: assert property (i_rx_bit_valid && !i_sync_on |=> !o_sync_found)
        else $error("sync found while disabled");
    cover property (o_sync_found);
    cover property (o_addr_reject);
    cover property (o_fifo_clear);
endmodule

bind radio_packet_sync_tx_config_regs radio_cfg_props i_radio_cfg_props (.i_ref_clk, .i_rst_n, .i_reg_wr,
    .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .i_sync_on, .i_rx_bit_valid, .o_sync_found,
    .i_rx_addr_valid, .o_addr_reject, .o_fifo_store_en, .i_rx_crc_done, .i_rx_crc_ok, .o_fifo_clear,
    .o_tx_cfg, .o_pkt_cfg, .o_clkout, .o_clkout_oe, .o_clkout_bypass);

//--- tb/radio_host_model.sv
// Host side model driving the register strobe port.
`timescale 1ns/100ps
module radio_host_model
(
    input wire logic i_ref_clk,
    output logic o_reg_wr,
    output logic o_reg_rd,
    output logic [4:0] o_reg_addr,
    output logic [7:0] o_reg_wdata
);
    logic [7:0] exp_q[$];
    initial
    begin
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        o_reg_addr = 5'h00;
        o_reg_wdata = 8'h00;
    end
    // Released address and data flip, so a stale value never passes for a held one.
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(negedge i_ref_clk);
        o_reg_wr = 1'b1;
        o_reg_addr = a;
        o_reg_wdata = d;
        @(negedge i_ref_clk);
        o_reg_wr = 1'b0;
        o_reg_addr = ~a;
        o_reg_wdata = ~d;
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        @(negedge i_ref_clk);
        o_reg_rd = 1'b1;
        o_reg_addr = a;
        exp_q.push_back(e);
        @(negedge i_ref_clk);
        o_reg_rd = 1'b0;
        o_reg_addr = ~a;
    endtask
endmodule

//--- tb/radio_packet_sync_tx_config_regs_tb_top.sv
// Self-checking bench of the radio configuration bank.
`timescale 1ns/100ps
module radio_packet_sync_tx_config_regs_tb_top import radio_cfg_pkg::*; ;
    logic clk, rst_n, sync_on, rx_bit, rx_bit_valid, rx_addr_valid, rx_crc_done, rx_crc_ok, standby;
    logic [1:0] sync_size, sync_tol;
    logic [7:0] rx_addr, wdata, rdata, d;
    logic reg_wr, reg_rd, found, store_en, rej, clr, wr_ok, rd_ok, clkout, oe, bypass, c, rj, st;
    logic rd_pend = 1'b0;
    logic [4:0] reg_addr, a;
    logic [31:0] pat;
    tx_cfg_s tx_cfg;
    pkt_cfg_s pkt_cfg;
    int error_cnt = 0;
    int num_checks = 0;
    int seed = 32'he48f;
    int n;
    logic [7:0] rst_vals [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h72, 8'hbc, 8'h00, 8'h00, 8'h48, 8'h00};
    logic [7:0] addrs [4] = '{8'h5a, 8'h00, 8'hff, 8'h33};

    radio_host_model i_radio_host_model (.i_ref_clk(clk), .o_reg_wr(reg_wr), .o_reg_rd(reg_rd),
        .o_reg_addr(reg_addr), .o_reg_wdata(wdata));
    radio_packet_sync_tx_config_regs i_radio_packet_sync_tx_config_regs (.i_ref_clk(clk), .i_rst_n(rst_n),
        .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_addr(reg_addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .i_sync_on(sync_on), .i_sync_size(sync_size), .i_sync_tol(sync_tol), .i_rx_bit(rx_bit),
        .i_rx_bit_valid(rx_bit_valid), .o_sync_found(found), .i_rx_addr_valid(rx_addr_valid),
        .i_rx_addr(rx_addr), .i_rx_crc_done(rx_crc_done), .i_rx_crc_ok(rx_crc_ok), .o_fifo_store_en(store_en),
        .o_addr_reject(rej), .o_fifo_clear(clr), .i_standby(standby), .o_host_fifo_wr_ok(wr_ok),
        .o_host_fifo_rd_ok(rd_ok), .o_tx_cfg(tx_cfg), .o_pkt_cfg(pkt_cfg), .o_clkout(clkout),
        .o_clkout_oe(oe), .o_clkout_bypass(bypass));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic conclude;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        num_checks++;
        if (s !== e)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic chk1(input string nm, input logic e, input logic s);
        chk(nm, {7'h0, e}, {7'h0, s});
    endtask
    task automatic wr(input logic [4:0] ad, input logic [7:0] dd);
        i_radio_host_model.wr(ad, dd);
    endtask
    task automatic rd(input logic [4:0] ad, input logic [7:0] e);
        i_radio_host_model.rd(ad, e);
    endtask

    // Expected read values are noted in the host queue and compared here half a cycle after the read edge.
    always @(posedge clk)
        rd_pend <= reg_rd && rst_n;
    always @(negedge clk)
        if (rd_pend === 1'b1)
            chk("reg_rdata", i_radio_host_model.exp_q.pop_front(), rdata);

    task automatic do_reset;
        @(negedge clk);
        rst_n = 1'b0;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        st = 1'b0;
        chk("clk_oe_rst", 8'h01, {7'h0, oe});
        for (int i = 0; i < REG_COUNT; i++)
            rd(ADDR_SYNC_MSB + 5'(i), rst_vals[i]);
        rd(5'h15, UNMAPPED_READ);
    endtask
    task automatic send(input logic [31:0] v, input int nb);
        for (int j = 31; j > 31 - nb; j--)
        begin
            @(negedge clk);
            rx_bit_valid = 1'b1;
            rx_bit = v[j];
        end
        @(negedge clk);
        rx_bit_valid = 1'b0;
        rx_bit = ~rx_bit;
    endtask
    task automatic pkt(input logic [7:0] ad, input logic ok, input logic r, input logic con, input logic acl);
        @(negedge clk);
        rx_addr_valid = 1'b1;
        rx_addr = ad;
        @(negedge clk);
        rx_addr_valid = 1'b0;
        rx_addr = ~ad;
        chk1("addr_reject", r, rej);
        chk1("store_en", !r, store_en);
        @(negedge clk);
        rx_crc_done = 1'b1;
        rx_crc_ok = ok;
        @(negedge clk);
        rx_crc_done = 1'b0;
        rx_crc_ok = ~ok;
        chk1("fifo_clear", !r && !ok && con && acl, clr);
        chk1("store_after", 1'b1, store_en);
        if (!r && con)
            st = ok;
    endtask

    initial
    begin
        #2000000;
        error_cnt++;
        conclude;
    end

    initial
    begin
        {rst_n, sync_on, rx_bit, rx_bit_valid, rx_addr_valid, rx_crc_done, rx_crc_ok, standby} = 8'h00;
        {sync_size, sync_tol, rx_addr} = 12'h000;
        do_reset;
        for (int i = 0; i < REG_COUNT; i++)
        begin
            d = 8'($random(seed));
            a = ADDR_SYNC_MSB + 5'(i);
            wr(a, d);
            rd(a, (a == ADDR_PKT_FORMAT) ? {d[7:1], st} : d);
            if (a == ADDR_TX_SETTINGS)
                chk("tx_cfg", d, tx_cfg);
            if (a == ADDR_CODING_LENGTH)
                chk("coding", d, {pkt_cfg.manchester_on, pkt_cfg.payload_length});
            if (a == ADDR_NODE_ADDRESS)
                chk("node", d, pkt_cfg.node_address);
            if (a == ADDR_PKT_FORMAT)
                chk("format", {1'b0, d[7:1]}, {1'b0, pkt_cfg.variable_length, pkt_cfg.preamble_code,
                    pkt_cfg.whitening_on, pkt_cfg.crc_on, pkt_cfg.addr_filter});
        end
        wr(ADDR_CLKOUT_SETTINGS, 8'h80);
        chk("clk_bypass", 8'h03, {6'h0, oe, bypass});
        wr(ADDR_CLKOUT_SETTINGS, 8'h04);
        chk("clk_off", 8'h00, {5'h0, clkout, oe, bypass});
        for (int k = 1; k < 4; k += 2)
        begin
            wr(ADDR_CLKOUT_SETTINGS, {1'b1, 5'(k), 2'b00});
            c = clkout;
            for (int j = 0; j < 8 && clkout === c; j++)
                @(negedge clk);
            repeat (2)
            begin
                c = clkout;
                repeat (k) @(negedge clk);
                chk1("clk_div", ~c, clkout);
            end
        end
        pat = $random(seed);
        for (int i = 0; i < 4; i++)
            wr(ADDR_SYNC_MSB + 5'(i), pat[31 - 8 * i -: 8]);
        sync_on = 1'b1;
        for (int s = 0; s < 4; s++)
        begin
            sync_size = 2'(s);
            sync_tol = 2'(s);
            n = 8 * (s + 1);
            send(pat ^ (((32'h1 << s) - 32'h1) << (32 - n)), n);
            chk1("sync_hit", 1'b1, found);
            send(pat ^ (((32'h1 << (s + 1)) - 32'h1) << (32 - n)), n);
            chk1("sync_miss", 1'b0, found);
        end
        sync_on = 1'b0;
        send(pat, 32);
        chk1("sync_off", 1'b0, found);
        wr(ADDR_NODE_ADDRESS, 8'h5a);
        wr(ADDR_FIFO_HANDLING, 8'h00);
        for (int m = 0; m < 4; m++)
        begin
            wr(ADDR_PKT_FORMAT, 8'h48 | 8'(m << 1));
            for (int k = 0; k < 4; k++)
            begin
                rj = !(m == 0 || addrs[k] == 8'h5a || (m >= 2 && addrs[k] == 8'h00) || (m == 3 && addrs[k] == 8'hff));
                pkt(addrs[k], 1'($random(seed)), rj, 1'b1, 1'b1);
                rd(ADDR_PKT_FORMAT, 8'h48 | 8'(m << 1) | {7'h0, st});
            end
        end
        wr(ADDR_PKT_FORMAT, 8'h40);
        pkt(8'h11, ~st, 1'b0, 1'b0, 1'b1);
        rd(ADDR_PKT_FORMAT, {7'h20, st});
        wr(ADDR_PKT_FORMAT, 8'h48);
        pkt(8'h11, 1'b0, 1'b0, 1'b1, 1'b1);
        wr(ADDR_FIFO_HANDLING, 8'h80);
        pkt(8'h11, 1'b0, 1'b0, 1'b1, 1'b0);
        rd(ADDR_PKT_FORMAT, 8'h48);
        standby = 1'b1;
        wr(ADDR_FIFO_HANDLING, 8'h40);
        chk("fifo_read", 8'h01, {6'h0, wr_ok, rd_ok});
        wr(ADDR_FIFO_HANDLING, 8'h00);
        chk("fifo_write", 8'h02, {6'h0, wr_ok, rd_ok});
        do_reset;
        repeat (4) @(negedge clk);
        conclude;
    end
endmodule

//--- verilog/radio_cfg_pkg.sv
// Package with offsets, reset values, field positions and carriers of the radio configuration bank.
package radio_cfg_pkg;

    // Register offsets, decimal 22 to 31.
    localparam logic [4:0] ADDR_SYNC_MSB = 5'h16;
    localparam logic [4:0] ADDR_SYNC_SECOND = 5'h17;
    localparam logic [4:0] ADDR_SYNC_THIRD = 5'h18;
    localparam logic [4:0] ADDR_SYNC_LSB = 5'h19;
    localparam logic [4:0] ADDR_TX_SETTINGS = 5'h1a;
    localparam logic [4:0] ADDR_CLKOUT_SETTINGS = 5'h1b;
    localparam logic [4:0] ADDR_CODING_LENGTH = 5'h1c;
    localparam logic [4:0] ADDR_NODE_ADDRESS = 5'h1d;
    localparam logic [4:0] ADDR_PKT_FORMAT = 5'h1e;
    localparam logic [4:0] ADDR_FIFO_HANDLING = 5'h1f;
    localparam int REG_COUNT = 10;

    // Values after reset.
    localparam logic [7:0] RST_SYNC_BYTE = 8'h00;
    localparam logic [7:0] RST_TX_SETTINGS = 8'h72;
    localparam logic [7:0] RST_CLKOUT_SETTINGS = 8'hbc;
    localparam logic [7:0] RST_CODING_LENGTH = 8'h00;
    localparam logic [7:0] RST_NODE_ADDRESS = 8'h00;
    localparam logic [7:0] RST_PKT_FORMAT = 8'h48;
    localparam logic [7:0] RST_FIFO_HANDLING = 8'h00;
    localparam logic RST_CRC_STATUS = 1'b0;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // Field positions.
    localparam int INTERP_MSB = 7;
    localparam int INTERP_LSB = 4;
    localparam int POWER_MSB = 3;
    localparam int POWER_LSB = 1;
    localparam int ZERO_IF_BIT = 0;
    localparam int CLKOUT_ON_BIT = 7;
    localparam int CLKDIV_MSB = 6;
    localparam int CLKDIV_LSB = 2;
    localparam int MANCHESTER_BIT = 7;
    localparam int LENGTH_MSB = 6;
    localparam int LENGTH_LSB = 0;
    localparam int VAR_LENGTH_BIT = 7;
    localparam int PREAMBLE_MSB = 6;
    localparam int PREAMBLE_LSB = 5;
    localparam int WHITENING_BIT = 4;
    localparam int CRC_ON_BIT = 3;
    localparam int ADDR_FILT_MSB = 2;
    localparam int ADDR_FILT_LSB = 1;
    localparam int CRC_STATUS_BIT = 0;
    localparam int AUTOCLR_OFF_BIT = 7;
    localparam int FIFO_READ_BIT = 6;

    // Address filter modes, broadcast addresses and the clock divider bypass code.
    localparam logic [1:0] FILT_OFF = 2'b00;
    localparam logic [1:0] FILT_NODE = 2'b01;
    localparam logic [1:0] FILT_NODE_ZERO = 2'b10;
    localparam logic [7:0] BCAST_ZERO = 8'h00;
    localparam logic [7:0] BCAST_ONES = 8'hff;
    localparam logic [4:0] CLKDIV_BYPASS = 5'h00;

    typedef enum logic [2:0] {
        PKT_IDLE = 3'b001,
        PKT_KEEP = 3'b010,
        PKT_DROP = 3'b100
    } pkt_state_e;

    typedef struct packed {
        logic [3:0] tx_interp_cutoff_code;
        logic [2:0] power_code;
        logic zero_if;
    } tx_cfg_s;

    typedef struct packed {
        logic manchester_on;
        logic [6:0] payload_length;
        logic variable_length;
        logic [1:0] preamble_code;
        logic whitening_on;
        logic crc_on;
        logic [1:0] addr_filter;
        logic [7:0] node_address;
    } pkt_cfg_s;

endpackage

//--- verilog/radio_packet_sync_tx_config_regs.sv
// Configuration bank for sync word, transmitter, clock output and packet handling of the radio.
//
// Summary of operation
// - Sync length code 00..11 selects an 8, 16, 24 or 32 bit pattern.
// - Sync recognition runs only while the sync enable input is high.
// - The detector tolerates up to the error count given by a two-bit code.
// - The first sync byte is always compared; the second when the length is not 00.
// - Third byte used for codes 1x, fourth for 11; all sync bytes reset to zero.
// - A four-bit code sets the transmit interpolation filter cutoff, reset 0111.
// - A three-bit code lowers transmit power in 3 dB steps, reset 001.
// - The zero-IF bit zeroes the first IF and ignores deviation in transmit.
// - The clock output pin is driven only while its enable bit is one.
// - Clock output is the crystal for code zero, else crystal over twice the code.
// - The line coding bit turns Manchester coding on for both directions.
// - Seven-bit length: exact length when fixed, receive maximum when variable.
// - An eight-bit node address, zero at reset, is compared when filtering.
// - Format bit zero means fixed length packets, one means variable length.
// - Two-bit preamble code plus one gives the preamble byte count, reset three bytes.
// - The whitening bit whitens transmit data and dewhitens receive data.
// - CRC generation and checking run while the CRC bit is one, its reset value.
// - Address filter modes: all, node only, node or zero, node or zero or ones.
// - A read-only status bit shows the CRC outcome of the current packet.
// - With auto-clear bit zero the FIFO is cleared when the packet fails CRC.
// - In standby the direction bit chooses host FIFO write or read access.
`timescale 1ns/100ps
module radio_packet_sync_tx_config_regs
    import radio_cfg_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [4:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    input wire logic i_sync_on,
    input wire logic [1:0] i_sync_size,
    input wire logic [1:0] i_sync_tol,
    input wire logic i_rx_bit,
    input wire logic i_rx_bit_valid,
    output logic o_sync_found,
    input wire logic i_rx_addr_valid,
    input wire logic [7:0] i_rx_addr,
    input wire logic i_rx_crc_done,
    input wire logic i_rx_crc_ok,
    output logic o_fifo_store_en,
    output logic o_addr_reject,
    output logic o_fifo_clear,
    input wire logic i_standby,
    output logic o_host_fifo_wr_ok,
    output logic o_host_fifo_rd_ok,
    output tx_cfg_s o_tx_cfg,
    output pkt_cfg_s o_pkt_cfg,
    output logic o_clkout,
    output logic o_clkout_oe,
    output logic o_clkout_bypass
);

    function automatic logic [7:0] reset_value(input int idx);
        logic [7:0] v;
        case (idx)
            4: v = RST_TX_SETTINGS;
            5: v = RST_CLKOUT_SETTINGS;
            6: v = RST_CODING_LENGTH;
            7: v = RST_NODE_ADDRESS;
            8: v = RST_PKT_FORMAT;
            9: v = RST_FIFO_HANDLING;
            default: v = RST_SYNC_BYTE;
        endcase
        return v;
    endfunction

    function automatic logic address_accepted(
        input logic [1:0] mode,
        input logic [7:0] node,
        input logic [7:0] addr
    );
        logic ok;
        case (mode)
            FILT_OFF: ok = 1'b1;
            FILT_NODE: ok = (addr == node);
            FILT_NODE_ZERO: ok = (addr == node) || (addr == BCAST_ZERO);
            default: ok = (addr == node) || (addr == BCAST_ZERO) || (addr == BCAST_ONES);
        endcase
        return ok;
    endfunction

    // Register storage; the slot for offset 30 keeps bit 0 as an unused copy.
    logic [7:0] regs [REG_COUNT];
    logic crc_status;
    pkt_state_e pkt_state;
    pkt_state_e next_pkt_state;
    logic [4:0] div_count;
    logic clk_level;

    // Address decode.
    wire in_range = (i_reg_addr >= ADDR_SYNC_MSB) && (i_reg_addr <= ADDR_FIFO_HANDLING);
    wire [4:0] reg_index_full = i_reg_addr - ADDR_SYNC_MSB;
    wire [3:0] reg_index = reg_index_full[3:0];
    wire write_hit = i_reg_wr && in_range;
    wire read_hit = i_reg_rd && in_range;

    // Named views of the stored fields.
    wire [7:0] tx_reg = regs[4];
    wire [7:0] clk_reg = regs[5];
    wire [7:0] coding_reg = regs[6];
    wire [7:0] node_reg = regs[7];
    wire [7:0] format_reg = regs[8];
    wire [7:0] fifo_reg = regs[9];
    wire [31:0] sync_pattern = {regs[0], regs[1], regs[2], regs[3]};

    wire clkout_on = clk_reg[CLKOUT_ON_BIT];
    wire [4:0] clk_div = clk_reg[CLKDIV_MSB:CLKDIV_LSB];
    wire crc_on = format_reg[CRC_ON_BIT];
    wire [1:0] addr_filter = format_reg[ADDR_FILT_MSB:ADDR_FILT_LSB];
    wire autoclr_off = fifo_reg[AUTOCLR_OFF_BIT];
    wire fifo_read_dir = fifo_reg[FIFO_READ_BIT];

    // Read path: the live status replaces the stored copy of bit 0 at offset 30.
    wire [7:0] stored_read = regs[reg_index];
    wire [7:0] status_read = {stored_read[7:1], crc_status};
    wire [7:0] read_value = (i_reg_addr == ADDR_PKT_FORMAT) ? status_read : stored_read;

    // Configuration carried to the modem and packet engine.
    assign o_tx_cfg.tx_interp_cutoff_code = tx_reg[INTERP_MSB:INTERP_LSB];
    assign o_tx_cfg.power_code = tx_reg[POWER_MSB:POWER_LSB];
    assign o_tx_cfg.zero_if = tx_reg[ZERO_IF_BIT];
    assign o_pkt_cfg.manchester_on = coding_reg[MANCHESTER_BIT];
    assign o_pkt_cfg.payload_length = coding_reg[LENGTH_MSB:LENGTH_LSB];
    assign o_pkt_cfg.variable_length = format_reg[VAR_LENGTH_BIT];
    assign o_pkt_cfg.preamble_code = format_reg[PREAMBLE_MSB:PREAMBLE_LSB];
    assign o_pkt_cfg.whitening_on = format_reg[WHITENING_BIT];
    assign o_pkt_cfg.crc_on = crc_on;
    assign o_pkt_cfg.addr_filter = addr_filter;
    assign o_pkt_cfg.node_address = node_reg;

    // Host FIFO direction only matters in standby; outside it the engine owns the FIFO.
    assign o_host_fifo_wr_ok = i_standby && !fifo_read_dir;
    assign o_host_fifo_rd_ok = i_standby && fifo_read_dir;

    sync_word_matcher u_sync
    (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_enable(i_sync_on),
        .i_bit(i_rx_bit),
        .i_bit_valid(i_rx_bit_valid),
        .i_pattern(sync_pattern),
        .i_size(i_sync_size),
        .i_tol(i_sync_tol),
        .o_found(o_sync_found)
    );

    // Register writes; reserved fields are stored like any other bit.
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            for (int i = 0; i < REG_COUNT; i++)
            begin
                regs[i] <= reset_value(i);
            end
        end
        else if (write_hit)
        begin
            regs[reg_index] <= i_reg_wdata;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            o_reg_rdata <= UNMAPPED_READ;
        end
        else if (i_reg_rd)
        begin
            o_reg_rdata <= read_hit ? read_value : UNMAPPED_READ;
        end
    end

    // Packet tracker: the address byte decides whether the packet is kept.
    wire addr_ok = address_accepted(addr_filter, node_reg, i_rx_addr);
    wire pkt_rejected = (pkt_state == PKT_DROP);
    wire crc_counts = i_rx_crc_done && crc_on && !pkt_rejected;
    // Only an address seen by the idle tracker may drop a packet; later address strobes are ignored.
    wire addr_drop = i_rx_addr_valid && !i_rx_crc_done && !addr_ok && (pkt_state == PKT_IDLE);

    always_comb
    begin
        next_pkt_state = pkt_state;
        case (pkt_state)
            PKT_IDLE:
            begin
                if (i_rx_addr_valid && !i_rx_crc_done)
                begin
                    next_pkt_state = addr_ok ? PKT_KEEP : PKT_DROP;
                end
            end
            PKT_KEEP:
            begin
                if (i_rx_crc_done)
                begin
                    next_pkt_state = PKT_IDLE;
                end
            end
            PKT_DROP:
            begin
                if (i_rx_crc_done)
                begin
                    next_pkt_state = PKT_IDLE;
                end
            end
            default:
            begin
                next_pkt_state = PKT_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            pkt_state <= PKT_IDLE;
        end
        else
        begin
            pkt_state <= next_pkt_state;
        end
    end

    // A dropped packet never reaches the FIFO, and the gate closes in the address cycle itself.
    assign o_fifo_store_en = !pkt_rejected && !addr_drop;

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            o_addr_reject <= 1'b0;
            o_fifo_clear <= 1'b0;
        end
        else
        begin
            o_addr_reject <= addr_drop;
            o_fifo_clear <= crc_counts && !i_rx_crc_ok && !autoclr_off;
        end
    end

    // Hardware owns the CRC status bit; host writes to offset 30 never reach it.
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            crc_status <= RST_CRC_STATUS;
        end
        else if (crc_counts)
        begin
            crc_status <= i_rx_crc_ok;
        end
    end

    // Clock output divider: the level toggles every clk_div cycles, giving the crystal over twice clk_div.
    wire div_bypass = (clk_div == CLKDIV_BYPASS);
    wire div_wrap = (div_count >= clk_div - 5'h01);

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            div_count <= 5'h00;
            clk_level <= 1'b0;
        end
        else if (div_bypass || !clkout_on)
        begin
            div_count <= 5'h00;
            clk_level <= 1'b0;
        end
        else if (div_wrap)
        begin
            div_count <= 5'h00;
            clk_level <= !clk_level;
        end
        else
        begin
            div_count <= div_count + 5'h01;
        end
    end

    // The raw crystal cannot leave through a flip-flop, so code zero asks the pad mux to pass it.
    assign o_clkout_bypass = clkout_on && div_bypass;
    assign o_clkout = clkout_on && clk_level;
    assign o_clkout_oe = clkout_on;

endmodule

//--- verilog/sync_word_matcher.sv
// Serial sync word matcher with selectable length and bit error tolerance.
`timescale 1ns/100ps
module sync_word_matcher
    import radio_cfg_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_enable,
    input wire logic i_bit,
    input wire logic i_bit_valid,
    input wire logic [31:0] i_pattern,
    input wire logic [1:0] i_size,
    input wire logic [1:0] i_tol,
    output logic o_found
);

    function automatic logic [5:0] ones_count(input logic [31:0] v);
        logic [5:0] n;
        n = 6'h00;
        for (int k = 0; k < 32; k++)
        begin
            n = n + {5'h00, v[k]};
        end
        return n;
    endfunction

    logic [31:0] shreg;
    wire [31:0] next_shreg = {shreg[30:0], i_bit};
    // The first sync byte goes out first, so a short word sits at the low end of the history.
    wire [31:0] aligned = i_pattern >> {3'h3 - {1'b0, i_size}, 3'h0};
    wire [31:0] mask = 32'hffffffff >> {3'h3 - {1'b0, i_size}, 3'h0};
    wire [5:0] errors = ones_count((next_shreg ^ aligned) & mask);
    wire hit = errors <= {4'h0, i_tol};

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            shreg <= 32'h00000000;
            o_found <= 1'b0;
        end
        else
        begin
            if (i_bit_valid)
            begin
                shreg <= next_shreg;
            end
            o_found <= i_bit_valid && i_enable && hit;
        end
    end

endmodule
